/* File: verilog/jfr_defs.svh */
// Purpose: shared constants of the 64b/66b framer link, both ends
// Assumes: one block moves per accepted link beat, bit p of a block is line position p
// Notes:   data word bit i travels at line position 2+i, so bit 0 is sent first
//
// Overview of operation
// - Pack 64-bit blocks, scramble, prepend 2-bit header
// - Header at positions 0-1, octets follow from 2
// - Thirty-two blocks make one multiblock
// - Extended multiblock length fixed at one
// - Local multiblock clock, phase reset by SYSREF
// - Every rising SYSREF edge restarts the multiblock and zeroes the parity sent
// - Sync header always 01 or 10
// - Stream one sent as 10, zero as 01
// - Thirty-two headers form one 32-bit stream word
// - Stream word ends with pilot 00001, bits 27-31
// - Bit 22 end-of-extended flag, always one
// - Stream carries CRC-12 only; no CRC-3, command
// - CRC over 2048 data bits, sent next multiblock
// - CRC bits placed MSB first in groups of three
// - Command positions always zero
// - Fixed ones at 3,7,11,15,19,21,23
// - CRC polynomial 0x987, applied serially
// - CRC cleared each multiblock, read after 2048 bits
// - Receiver finds blocks by steady header transitions
// - Receiver checks CRC against next multiblock's parity
// - Pilot unique, so one multiblock gives alignment
`ifndef JFR_DEFS_SVH
`define JFR_DEFS_SVH

`define JFR_DW          64
`define JFR_BW          66
`define JFR_MB_BLKS     32
`define JFR_IDX_W       5
`define JFR_E           1
`define JFR_CRC_W       12
// Normal-form taps of x^12+x^9+x^8+x^3+x^2+x+1 (0x987 in the implicit-one notation)
`define JFR_CRC_TAPS    12'h30f
`define JFR_SCR_W       58
`define JFR_SCR_TAP_A   38
`define JFR_SCR_TAP_B   57
`define JFR_SCR_SEED    58'h3ffffffffffffff
`define JFR_SH_ONE      2'b10
`define JFR_SH_ZERO     2'b01
`define JFR_PILOT       5'h10
`define JFR_EOEMB_BIT   22
`define JFR_SHW_FIXED   32'h80e88888
`define JFR_SHW_CRC_MSK 32'h00007777
`define JFR_BUF_DEPTH   2
`define JFR_SH_LOCK_CNT 64
`define JFR_ERR_MAX     4

`endif

/* File: verilog/jfr_pkg.sv */
// Purpose: types and shared arithmetic of the framer link
// Assumes: jfr_defs.svh constants
// Notes:   scrambler and CRC walk bits in line order, lowest data bit first
`include "jfr_defs.svh"

package jfr_pkg;

    typedef enum logic [1:0] {JFR_HUNT_BLK, JFR_HUNT_MB, JFR_LOCKED} jfr_rx_mode_t;

    typedef struct packed {
        logic                    sr_m;
        logic                    sr_s;
        logic                    sr_p;
        logic                    rst_pend;
        logic                    vld;
        logic [`JFR_BW-1:0]      blk;
        logic                    lemc;
        logic [`JFR_IDX_W-1:0]   idx;
        logic [`JFR_CRC_W-1:0]   crc;
        logic [`JFR_CRC_W-1:0]   crc_prev;
        logic [`JFR_SCR_W-1:0]   scr;
    } jfr_tx_st_t;

    typedef struct packed {
        jfr_rx_mode_t                            mode;
        logic [6:0]                              cnt;
        logic [2:0]                              errs;
        logic [`JFR_IDX_W-1:0]                   idx;
        logic [31:0]                             shw;
        logic [`JFR_CRC_W-1:0]                   crc;
        logic [`JFR_CRC_W-1:0]                   crc_prev;
        logic                                    have_prev;
        logic [`JFR_SCR_W-1:0]                   scr;
        logic [`JFR_BUF_DEPTH-1:0][`JFR_DW-1:0]  fifo;
        logic                                    wp;
        logic                                    rp;
        logic [1:0]                              fill;
        logic                                    crc_err;
        logic                                    sh_err;
        logic                                    mb_err;
    } jfr_rx_st_t;

    // Serial CRC-12 over one block, bit 0 first
    function automatic logic [`JFR_CRC_W-1:0] jfr_crc64(logic [`JFR_CRC_W-1:0] c, logic [`JFR_DW-1:0] d);
        logic fb;
        fb = 1'b0;
        for (int i = 0; i < `JFR_DW; i++) begin
            fb = c[`JFR_CRC_W-1] ^ d[i];
            c  = {c[`JFR_CRC_W-2:0], 1'b0} ^ (fb ? `JFR_CRC_TAPS : 12'h000);
        end
        return c;
    endfunction

    // Self-synchronous 1+x^39+x^58; desc picks which bit feeds the register
    function automatic logic [`JFR_SCR_W+`JFR_DW-1:0] jfr_scr64(logic [`JFR_DW-1:0] d,
                                                              logic [`JFR_SCR_W-1:0] st, logic desc);
        logic [`JFR_DW-1:0] o;
        o = '0;
        for (int i = 0; i < `JFR_DW; i++) begin
            o[i] = d[i] ^ st[`JFR_SCR_TAP_A] ^ st[`JFR_SCR_TAP_B];
            st   = {st[`JFR_SCR_W-2:0], desc ? d[i] : o[i]};
        end
        return {st, o};
    endfunction

    // Stream word: fixed pilot, ones, flag and zeros, with parity in groups of three
    function automatic logic [31:0] jfr_shw(logic [`JFR_CRC_W-1:0] c);
        logic [31:0] w;
        w = `JFR_SHW_FIXED;
        for (int g = 0; g < 4; g++) begin
            for (int k = 0; k < 3; k++) begin
                w[4*g+k] = c[11-3*g-k];
            end
        end
        return w;
    endfunction

    function automatic logic [`JFR_CRC_W-1:0] jfr_shw_crc(logic [31:0] w);
        logic [`JFR_CRC_W-1:0] c;
        c = '0;
        for (int g = 0; g < 4; g++) begin
            for (int k = 0; k < 3; k++) begin
                c[11-3*g-k] = w[4*g+k];
            end
        end
        return c;
    endfunction

endpackage

/* File: verilog/jfr_link_if.sv */
// Purpose: parallel 66-bit block link between framer and receiver
// Assumes: one block per beat when vld and rdy are both high
// Notes:   rdy stands in for the serialiser and lets the far end apply back-pressure
`timescale 1ns/10ps

interface jfr_link_if;
    logic [65:0] blk;
    logic        vld;
    logic        rdy;

    modport tx (output blk, output vld, input rdy);
    modport rx (input blk, input vld, output rdy);
endinterface

/* File: verilog/jfr_tx.sv */
// Purpose: transmit end, packs user words into framed 66-bit blocks with CRC-12 stream
// Assumes: CLK 40 MHz, RST asynchronous active high, SYSREF from a pin
// Notes:   an idle user side is filled with zero data so the multiblock never stops
`timescale 1ns/10ps
`include "jfr_defs.svh"

module jfr_tx (
    input  wire logic               CLK,      // System clock
    input  wire logic               RST,      // Asynchronous reset, active high
    input  wire logic               SYSREF,   // Phase reference pin, rising edge used
    input  wire logic [63:0]        DIN,      // User block, octet k in bits 8k+7..8k
    input  wire logic               DIN_VLD,  // User block valid
    output logic                    DIN_RDY,  // User block taken this cycle
    output logic                    LEMC,     // Pulse with the first block of each multiblock
    jfr_link_if.tx                  LNK       // Block link
);
    import jfr_pkg::*;

    // ****************************************************************
    // State
    // ****************************************************************
    jfr_tx_st_t s;
    jfr_tx_st_t n;

    logic                       edge_seen;
    logic                       phase_rst;
    logic                       load;
    logic [`JFR_IDX_W-1:0]      idx;
    logic [`JFR_DW-1:0]         data;
    logic [`JFR_DW-1:0]         sdata;
    logic [`JFR_SCR_W-1:0]      scr_n;
    logic [`JFR_CRC_W-1:0]      crc_in;
    logic [`JFR_CRC_W-1:0]      crc_n;
    logic [`JFR_CRC_W-1:0]      prev;
    logic [31:0]                shw;
    logic                       hbit;

    // ****************************************************************
    // Handshake
    // ****************************************************************
    // A block is loaded whenever the output stage is empty or being drained,
    // so the link ready reaches the user without an extra cycle of latency.
    assign load    = !s.vld || LNK.rdy;
    assign DIN_RDY = load;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        n = s;

        // Pin synchroniser; the edge is taken from the second stage and its delayed copy
        n.sr_m = SYSREF;
        n.sr_s = s.sr_m;
        n.sr_p = s.sr_s;
        edge_seen = s.sr_s && !s.sr_p;

        // A SYSREF edge waits for the next block slot, then restarts the
        // multiblock there; the truncated multiblock's parity is discarded.
        phase_rst = s.rst_pend || edge_seen;
        if (edge_seen) begin
            n.rst_pend = 1'b1;
        end

        idx    = phase_rst ? '0 : s.idx;
        prev   = phase_rst ? '0 : s.crc_prev;

        // Idle slots carry zero data, still scrambled and covered by parity
        data   = DIN_VLD ? DIN : '0;
        {scr_n, sdata} = jfr_scr64(data, s.scr, 1'b0);

        // Parity restarts from zero on the first block of every multiblock
        crc_in = (idx == '0) ? '0 : s.crc;
        crc_n  = jfr_crc64(crc_in, sdata);

        // Stream word of this multiblock carries last multiblock's parity
        shw    = jfr_shw(prev);
        hbit   = shw[idx];

        n.lemc = 1'b0;
        if (load) begin
            n.vld      = 1'b1;
            n.rst_pend = 1'b0;
            // Header in positions 0-1, data from position 2 upward
            n.blk      = {sdata, hbit ? `JFR_SH_ONE : `JFR_SH_ZERO};
            n.scr      = scr_n;
            n.crc      = crc_n;
            n.crc_prev = prev;
            n.idx      = idx + 1'b1;
            n.lemc     = (idx == '0);
            // After 2048 bits the parity is frozen for the next multiblock
            if (idx == `JFR_IDX_W'(`JFR_MB_BLKS - 1)) begin
                n.crc_prev = crc_n;
            end
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            s.sr_m     <= 1'b0;
            s.sr_s     <= 1'b0;
            s.sr_p     <= 1'b0;
            s.rst_pend <= 1'b0;
            s.vld      <= 1'b0;
            s.blk      <= '0;
            s.lemc     <= 1'b0;
            s.idx      <= '0;
            s.crc      <= '0;
            s.crc_prev <= '0;
            s.scr      <= `JFR_SCR_SEED;
        end else begin
            s <= n;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // Extended multiblock length is one, so the local clock edge is the
    // multiblock edge and the end-of-extended flag is set in every word.
    assign LEMC    = s.lemc;
    assign LNK.blk = s.blk;
    assign LNK.vld = s.vld;

endmodule // jfr_tx

/* File: verilog/jfr_rx.sv */
// Purpose: receive end, checks headers, aligns multiblocks, checks CRC-12, buffers data
// Assumes: CLK 40 MHz, RST asynchronous active high, blocks arrive already word aligned
// Notes:   the two-entry buffer stalls the link when the user stops taking words
`timescale 1ns/10ps
`include "jfr_defs.svh"

module jfr_rx #(
    parameter int SH_LOCK_CNT = `JFR_SH_LOCK_CNT,  // Good headers needed for block lock
    parameter int ERR_MAX     = `JFR_ERR_MAX        // Errors in a row that drop lock
) (
    input  wire logic               CLK,         // System clock
    input  wire logic               RST,         // Asynchronous reset, active high
    jfr_link_if.rx                  LNK,         // Block link
    output logic [63:0]             DOUT,        // Descrambled user block
    output logic                    DOUT_VLD,    // User block valid
    input  wire logic               DOUT_RDY,    // User takes the block
    output logic                    LOCKED,      // Multiblock alignment held
    output logic                    RESYNC_REQ,  // Block lock lost, reissue SYSREF
    output logic                    CRC_ERR,     // Parity mismatch pulse
    output logic                    SH_ERR,      // Invalid header pulse while locked
    output logic                    MB_ERR       // Bad pilot word pulse while locked
);
    import jfr_pkg::*;

    // ****************************************************************
    // State
    // ****************************************************************
    jfr_rx_st_t s;
    jfr_rx_st_t n;

    logic                   take;
    logic                   shok;
    logic [31:0]            w;
    logic [`JFR_DW-1:0]     dd;
    logic [`JFR_SCR_W-1:0]  scr_n;
    logic [`JFR_CRC_W-1:0]  crc_n;
    logic                   pop;
    logic                   push;
    logic                   err;
    logic                   word_ok;

    assign LNK.rdy = (s.fill != 2'(`JFR_BUF_DEPTH));
    assign take    = LNK.vld && LNK.rdy;
    assign pop     = (s.fill != 2'h0) && DOUT_RDY;

    always_comb begin
        n = s;
        n.crc_err = 1'b0;
        n.sh_err  = 1'b0;
        n.mb_err  = 1'b0;
        push = 1'b0;
        err  = 1'b0;
        shok = LNK.blk[0] ^ LNK.blk[1];
        w    = {LNK.blk[1:0] == `JFR_SH_ONE, s.shw[31:1]};
        {scr_n, dd} = jfr_scr64(LNK.blk[65:2], s.scr, 1'b1);
        crc_n   = jfr_crc64((s.idx == '0) ? '0 : s.crc, LNK.blk[65:2]);
        word_ok = (w[31:27] == `JFR_PILOT) && ((w & ~`JFR_SHW_CRC_MSK) == `JFR_SHW_FIXED);
        if (take) begin
            n.shw = w;
            n.scr = scr_n;
            case (s.mode)
                JFR_HUNT_BLK: begin
                    n.cnt = shok ? s.cnt + 1'b1 : '0;
                    if (shok && s.cnt == 7'(SH_LOCK_CNT - 1)) begin
                        n.mode = JFR_HUNT_MB;
                    end
                end
                JFR_HUNT_MB: begin
                    // Pilot is unique in the word, so one match aligns
                    if (!shok) begin
                        n.mode = JFR_HUNT_BLK;
                        n.cnt  = '0;
                    end else if (word_ok) begin
                        n.mode      = JFR_LOCKED;
                        n.idx       = '0;
                        n.errs      = '0;
                        n.have_prev = 1'b0;
                    end
                end
                JFR_LOCKED: begin
                    push  = 1'b1;
                    n.idx = s.idx + 1'b1;
                    n.crc = crc_n;
                    if (!shok) begin
                        n.sh_err = 1'b1;
                        err      = 1'b1;
                    end
                    if (s.idx == `JFR_IDX_W'(`JFR_MB_BLKS - 1)) begin
                        if (!word_ok) begin
                            n.mb_err = 1'b1;
                            err      = 1'b1;
                        end
                        n.crc_err   = s.have_prev && (jfr_shw_crc(w) != s.crc_prev);
                        n.crc_prev  = crc_n;
                        n.have_prev = 1'b1;
                        if (!err) begin
                            n.errs = '0;
                        end
                    end
                    if (err) begin
                        n.errs = s.errs + 1'b1;
                        if (s.errs == 3'(ERR_MAX - 1)) begin
                            n.mode = JFR_HUNT_BLK;
                            n.cnt  = '0;
                        end
                    end
                end
                default: begin
                    n.mode = JFR_HUNT_BLK;
                end
            endcase
        end
        if (push) begin
            n.fifo[s.wp] = dd;
            n.wp         = ~s.wp;
        end
        if (pop) begin
            n.rp = ~s.rp;
        end
        n.fill = s.fill + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            s       <= '0;
            s.mode  <= JFR_HUNT_BLK;
            s.scr   <= `JFR_SCR_SEED;
        end else begin
            s <= n;
        end
    end

    assign DOUT       = s.fifo[s.rp];
    assign DOUT_VLD   = (s.fill != 2'h0);
    assign LOCKED     = (s.mode == JFR_LOCKED);
    assign RESYNC_REQ = (s.mode == JFR_HUNT_BLK);
    assign CRC_ERR    = s.crc_err;
    assign SH_ERR     = s.sh_err;
    assign MB_ERR     = s.mb_err;

endmodule // jfr_rx

/* File: sim/jfr_link_properties.sv */
// Purpose: checks on the block link wire and its sync header stream word
// Assumes: blk[1:0] of 2'b10 carries a stream one, data bit i at blk[2+i]
// Notes:   own serial parity model; a word is judged only when all 32 headers came in
`timescale 1ns/10ps

module jfr_link_properties (
    input wire logic        CLK,   // System clock
    input wire logic        RST,   // Reset, active high
    input wire logic [65:0] blk,   // Link block
    input wire logic        vld,   // Block valid
    input wire logic        rdy,   // Receiver ready
    input wire logic        LEMC   // First block of a multiblock
);
    import jfr_pkg::*;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    // ************************************************************
    // Helper model of the stream word and parity
    // ************************************************************
    logic [4:0]  idx_q;
    logic [31:0] shw_q;
    logic [11:0] crc_q, prev_q, exp_q;
    logic        seen_q, ok_q, eok_q, done_q;
    wire         take = vld && rdy;
    wire [4:0]   cur  = LEMC ? 5'h00 : idx_q;
    function automatic logic [11:0] crc_step(logic [11:0] c, logic [63:0] d);
        for (int i = 0; i < 64; i++) c = {c[10:0], 1'b0} ^ ((c[11] ^ d[i]) ? 12'h30f : 12'h000);
        return c;
    endfunction
    wire [11:0]  crc_nx = crc_step(LEMC ? 12'h000 : crc_q, blk[65:2]);
    wire [11:0]  w_crc  = {shw_q[0], shw_q[1], shw_q[2], shw_q[4], shw_q[5], shw_q[6],
                           shw_q[8], shw_q[9], shw_q[10], shw_q[12], shw_q[13], shw_q[14]};
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            {idx_q, shw_q, crc_q, prev_q, exp_q} <= '0;
            {seen_q, ok_q, eok_q, done_q} <= 4'h0;
        end else begin
            done_q <= take && (cur == 5'h1f) && seen_q;
            if (take) begin
                shw_q[cur] <= (blk[1:0] == 2'b10);
                crc_q      <= crc_nx;
                idx_q      <= cur + 5'h01;
                if (LEMC) seen_q <= 1'b1;
                // A cut multiblock leaves no parity worth comparing
                if (LEMC && idx_q != 5'h00) ok_q <= 1'b0;
                if (cur == 5'h1f) begin
                    prev_q <= crc_nx;
                    ok_q   <= 1'b1;
                    exp_q  <= prev_q;
                    eok_q  <= ok_q;
                end
            end
        end
    end
    // ************************************************************
    // Properties
    // ************************************************************
    sequence s_take; vld && rdy; endsequence
    sequence s_stall; vld && !rdy; endsequence
    sequence s_word; done_q; endsequence
    a_hdr_opposite: assert property (vld |-> blk[0] != blk[1]) else $error("sync header not complementary");
    a_blk_hold: assert property (s_stall |=> vld && $stable(blk)) else $error("block changed while stalled");
    a_vld_kept: assert property (vld |=> vld) else $error("block stream stopped");
    a_mb_wrap: assert property (s_take ##0 cur == 5'h1f |=> LEMC) else $error("no multiblock start after 32");
    a_pilot_end: assert property (s_word |-> shw_q[31:27] == 5'h10) else $error("pilot missing");
    a_eoemb_set: assert property (s_word |-> shw_q[22]) else $error("extended end flag clear");
    a_cmd_zero: assert property (s_word |-> (shw_q & 32'h07170000) == 32'h0) else $error("command bit set");
    a_fixed_ones: assert property (s_word |-> (shw_q & 32'h00a88888) == 32'h00a88888) else $error("fixed one missing");
    a_crc_next: assert property (s_word ##0 eok_q |-> w_crc == exp_q) else $error("parity wrong");
endmodule // jfr_link_properties

/* File: sim/tb_jesd204c_64b66b_crc12_framer.sv */
// Purpose: framer and receiver facing each other, plus a receiver on a corrupted copy
// Assumes: 40 MHz clock, short lock count for speed
// Notes:   the corrupted copy only sees blocks the clean receiver takes
`timescale 1ns/10ps

module tb_jesd204c_64b66b_crc12_framer;
    import jfr_pkg::*;
    logic        CLK = 0, RST = 1, SYSREF = 0, DIN_VLD = 0, DOUT_RDY = 0;
    logic [63:0] DIN = '0, DOUT, rx_word;
    logic        DIN_RDY, LEMC, DOUT_VLD, LOCKED, RESYNC_REQ, CRC_ERR, SH_ERR, MB_ERR;
    logic        LOCKED2, CRC_ERR2, SH_ERR2;
    logic [65:0] err_mask = '0;
    int          num_errors = 0, comparisons = 0, cyc = 0, crc1 = 0, crc2 = 0, sh2 = 0, sh1 = 0, mb1 = 0, n;
    always #12.5 CLK = ~CLK;
    // ************************************************************
    // Instances
    // ************************************************************
    jfr_link_if lnk ();
    jfr_link_if lnk_bad ();
    assign lnk_bad.blk = lnk.blk ^ err_mask;
    assign lnk_bad.vld = lnk.vld & lnk.rdy;
    jfr_tx jfr_tx_inst (.CLK(CLK), .RST(RST), .SYSREF(SYSREF), .DIN(DIN), .DIN_VLD(DIN_VLD),
                        .DIN_RDY(DIN_RDY), .LEMC(LEMC), .LNK(lnk.tx));
    jfr_rx #(.SH_LOCK_CNT(8), .ERR_MAX(4)) jfr_rx_inst (.CLK(CLK), .RST(RST), .LNK(lnk.rx),
        .DOUT(DOUT), .DOUT_VLD(DOUT_VLD), .DOUT_RDY(DOUT_RDY), .LOCKED(LOCKED),
        .RESYNC_REQ(RESYNC_REQ), .CRC_ERR(CRC_ERR), .SH_ERR(SH_ERR), .MB_ERR(MB_ERR));
    jfr_rx #(.SH_LOCK_CNT(8), .ERR_MAX(4)) jfr_rx_inst2 (.CLK(CLK), .RST(RST), .LNK(lnk_bad.rx),
        .DOUT(), .DOUT_VLD(), .DOUT_RDY(1'b1), .LOCKED(LOCKED2), .RESYNC_REQ(),
        .CRC_ERR(CRC_ERR2), .SH_ERR(SH_ERR2), .MB_ERR());
    jfr_link_properties jfr_link_properties_inst (.CLK(CLK), .RST(RST), .blk(lnk.blk),
        .vld(lnk.vld), .rdy(lnk.rdy), .LEMC(LEMC));
    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic put_word(input logic [63:0] v);
        DIN     <= v;
        DIN_VLD <= 1'b1;
        do @(negedge CLK); while (DIN_RDY !== 1'b1);
        @(posedge CLK);
    endtask
    task automatic get_word(output logic [63:0] v);
        DOUT_RDY <= 1'b1;
        do @(negedge CLK); while (DOUT_VLD !== 1'b1);
        v = DOUT;
        @(posedge CLK);
    endtask
    // Corrupts exactly one block on the copy
    task automatic inject(input logic [65:0] m);
        @(posedge CLK);
        err_mask <= m;
        do @(negedge CLK); while (!(lnk.vld && lnk.rdy));
        @(posedge CLK);
        err_mask <= '0;
        repeat (80) @(posedge CLK);
    endtask
    function automatic logic [63:0] pat(input int k);
        return {32'ha5a50000 | k, 32'h0f0f0000 | k};
    endfunction
    task complete_run;
        $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // A hang past the expected run length ends the test
    always @(posedge CLK) begin
        cyc++;
        crc1 += CRC_ERR;
        crc2 += CRC_ERR2;
        sh2  += SH_ERR2;
        sh1  += SH_ERR;
        mb1  += MB_ERR;
        if (cyc == 3000) begin
            num_errors++;
            complete_run();
        end
    end
    // ************************************************************
    // Tests
    // ************************************************************
    initial begin
        repeat (10) @(posedge CLK);
        RST      <= 1'b0;
        DOUT_RDY <= 1'b1;
        for (n = 0; n < 400 && LOCKED !== 1'b1; n++) @(negedge CLK);
        check({LOCKED, RESYNC_REQ, LOCKED2}, 3'b101);
        $display("test lock done");
        @(posedge CLK);
        DOUT_RDY <= 1'b0;
        repeat (6) @(posedge CLK);
        @(negedge CLK);
        check({lnk.rdy, DIN_RDY, DOUT_VLD}, 3'b001);
        $display("test stall done");
        // Stimulus changes only on the rising edge
        @(posedge CLK);
        fork
            begin
                for (int k = 0; k < 40; k++) put_word(pat(k));
                DIN_VLD <= 1'b0;
            end
            begin
                rx_word = '0;
                for (n = 0; n < 200 && rx_word === 64'h0; n++) get_word(rx_word);
                check(rx_word, pat(0));
                for (int k = 1; k < 40; k++) begin
                    if (k % 5 == 0) begin
                        DOUT_RDY <= 1'b0;
                        repeat (4) @(posedge CLK);
                    end
                    get_word(rx_word);
                    check(rx_word, pat(k));
                end
            end
        join
        $display("test data done");
        inject(66'h400);
        check({crc1, crc2}, {32'd0, 32'd1});
        // Flipping one header bit makes it 00 or 11; flipping both would stay legal
        inject(66'h1);
        check({sh2, 31'd0, LOCKED2}, {32'd1, 32'd1});
        $display("test errors done");
        do @(negedge CLK); while (LEMC !== 1'b1);
        repeat (10) @(posedge CLK);
        SYSREF <= 1'b1;
        n = 0;
        do begin
            @(negedge CLK);
            n++;
        end while (LEMC !== 1'b1 && n < 40);
        check(n >= 3 && n <= 5, 1'b1);
        check(lnk.blk[1:0], 2'b01);
        n = 0;
        do begin
            @(negedge CLK);
            n++;
        end while (LEMC !== 1'b1 && n < 100);
        check(n, 32);
        // The cut multiblock shifts the clean receiver's word boundary, so its next word lacks the pilot
        check({sh1, mb1}, {32'd0, 32'd1});
        $display("test sysref done");
        complete_run();
    end
endmodule // tb_jesd204c_64b66b_crc12_framer
